// ===== rtl/cantsa_pkg.sv
// Purpose: Shared constants and carriers for the CAN transmit select and acceptance slice
// Assumes: APB with 32-bit data; register index times four gives the byte address
// Notes:   Eight-bit registers sit in the low bits of each word, upper bits read zero
package cantsa_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W    = 12;
    localparam int DATA_W    = 32;
    localparam int IDX_W     = 10;
    localparam int NUM_TXB   = 3;
    localparam int WIN_BYTES = 16;

    // ==========================================================
    // Register indices
    localparam logic [IDX_W-1:0] IDX_ABORT_REQ  = 10'h008;
    localparam logic [IDX_W-1:0] IDX_ABORT_ACK  = 10'h009;
    localparam logic [IDX_W-1:0] IDX_TXB_SELECT = 10'h00A;
    localparam logic [IDX_W-1:0] IDX_ACCEPT_CTL = 10'h00B;
    localparam logic [IDX_W-1:0] IDX_RSVD_LO    = 10'h00C;
    localparam logic [IDX_W-1:0] IDX_RSVD_HI    = 10'h00D;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h010;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h011;
    localparam logic [IDX_W-1:0] IDX_WIN_BASE   = 10'h020;

    // ==========================================================
    // Field positions
    localparam int MODE_LSB = 4;
    localparam int HIT_LSB  = 0;
    localparam int IRQ_W    = 3;
    localparam int IRQ_ABORT   = 0;
    localparam int IRQ_RXHIT   = 1;
    localparam int IRQ_BLOCKED = 2;

    // ==========================================================
    // Reset values
    localparam logic [NUM_TXB-1:0] TXB_RST     = 3'h0;
    localparam logic [NUM_TXB-1:0] TXEMPTY_RST = 3'h7;
    localparam logic [2:0]         HIT_RST     = 3'h0;
    localparam logic [IRQ_W-1:0]   IRQ_RST     = 3'h0;
    localparam logic [7:0]         BYTE_RST    = 8'h00;

    typedef enum logic [1:0] {
        FILT_TWO32   = 2'h0,
        FILT_FOUR16  = 2'h1,
        FILT_EIGHT8  = 2'h2,
        FILT_CLOSED  = 2'h3
    } cantsa_mode_type;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } cantsa_apb_req_type;

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } cantsa_apb_rsp_type;

endpackage

// ===== rtl/cantsa_top.sv
// Purpose: Abort acknowledge, transmit buffer select, shared window and acceptance control
// Assumes: All controller-side inputs come from logic on clk_sys; no synchronisers needed
// Notes:   APB answers two cycles after setup; windowed buffers are stored here
// Notes:   Mode register survives init mode; only reset clears it
`timescale 1ns/1ps

// Summary of operation
// - Abort acknowledge is read-only and held at reset while init mode is active.
// - A buffer's abort acknowledge sets when its message was aborted on request.
// - A buffer's abort acknowledge clears when its transmit-empty flag is cleared.
// - Only the lowest set select bit maps its buffer into the shared window.
// - Reading the select register returns only its lowest set bit.
// - The select register is writable only outside init mode and held at reset in it.
// - Window accesses are refused while the selected buffer is not empty.
// - Window accesses are refused when no buffer is selected.
// - The mode field picks two 32-bit, four 16-bit, eight 8-bit filters or closed.
// - In closed mode no message is accepted and the foreground is never reloaded.
// - The hit field reports the matching filter as a binary index 0 to 7.
// - The hit field follows the foreground message and updates on each shift in outside closed mode.
// - Acceptance control is writable only in init mode; hit bits are always read-only.
// - The reserved pair reads zero and ignores writes in normal operation.
// - An abort is granted only before transmission starts or after it failed.
// - Abort request clears while transmit-empty is set; software cannot clear it.
module cantsa_top
    import cantsa_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // Register bus
    input  wire cantsa_apb_req_type  apbReq,
    output cantsa_apb_rsp_type       apbRsp,
    // Init handshake
    input  wire logic                initRequest,
    input  wire logic                initAcknowledge,
    // Transmit side
    input  wire logic [NUM_TXB-1:0]  txEmpty,
    input  wire logic [NUM_TXB-1:0]  txStarted,
    input  wire logic [NUM_TXB-1:0]  txFailed,
    input  wire logic [NUM_TXB-1:0]  abortDone,
    output logic      [NUM_TXB-1:0]  abortRequest,
    output logic      [NUM_TXB-1:0]  abortGrant,
    output logic      [NUM_TXB-1:0]  txBufSelect,
    // Receive side
    input  wire logic                rxShift,
    input  wire logic [2:0]          rxHitIndex,
    output cantsa_mode_type          acceptMode,
    output logic                     acceptEnable,
    // Interrupt
    output logic                     irq
);

    // ==========================================================
    // Helpers
    function automatic logic [NUM_TXB-1:0] lowestBit(input logic [NUM_TXB-1:0] v);
        logic [NUM_TXB-1:0] r;
        r = v & (~v + 3'h1);
        return r;
    endfunction

    function automatic logic [1:0] bufIndex(input logic [NUM_TXB-1:0] oneHot);
        logic [1:0] r;
        r = oneHot[1] ? 2'h1 : (oneHot[2] ? 2'h2 : 2'h0);
        return r;
    endfunction

    function automatic logic hitReg(input logic [IDX_W-1:0] at, input logic [IDX_W-1:0] want);
        return at == want;
    endfunction

    // ==========================================================
    // State
    logic [NUM_TXB-1:0]   abortReq_q;
    logic [NUM_TXB-1:0]   abortAck_q;
    logic [NUM_TXB-1:0]   selRaw_q;
    logic [NUM_TXB-1:0]   txEmptyPrev_q;
    cantsa_mode_type      mode_q;
    logic [2:0]           hitIndex_q;
    logic [IRQ_W-1:0]     irqStatus_q;
    logic [IRQ_W-1:0]     irqMask_q;
    cantsa_apb_rsp_type   rsp_q;
    logic [7:0]           txBuf_q [NUM_TXB][WIN_BYTES];

    logic                 initMode;
    logic                 writeOpen;
    logic [IDX_W-1:0]     idx;
    logic [3:0]           winOff;
    logic                 inWindow;
    logic [NUM_TXB-1:0]   selOneHot;
    logic [1:0]           selIdx;
    logic                 winOk;
    logic                 accessPhase;
    logic                 firstAccess;
    logic                 wrCommit;
    logic                 errNow;
    logic [DATA_W-1:0]    readNow;
    logic [7:0]           wByte;
    logic [NUM_TXB-1:0]   emptyFall;
    logic [NUM_TXB-1:0]   ackSet;
    logic                 hitUpdate;
    logic [IRQ_W-1:0]     irqEvent;
    logic                 wrAbortReq;
    logic                 wrSelect;
    logic                 wrAccept;
    logic                 wrIrqStatus;
    logic                 wrIrqMask;
    logic [NUM_TXB-1:0]   abortReqSet;

    // ==========================================================
    // Decode
    assign initMode    = initRequest & initAcknowledge;
    assign writeOpen   = ~initRequest & ~initAcknowledge;
    assign idx         = apbReq.paddr[ADDR_W-1:2];
    assign winOff      = idx[3:0];
    assign inWindow    = (idx[IDX_W-1:4] == IDX_WIN_BASE[IDX_W-1:4]);
    assign wByte       = apbReq.pwdata[7:0];
    assign accessPhase = apbReq.psel & apbReq.penable;
    // Response computed on the first access cycle, write lands on the completing edge
    assign firstAccess = accessPhase & ~rsp_q.pready;
    assign wrCommit    = accessPhase & rsp_q.pready & apbReq.pwrite & ~rsp_q.pslverr;

    assign selOneHot = lowestBit(selRaw_q);
    assign selIdx    = bufIndex(selOneHot);
    assign winOk     = (|selOneHot) && ((selOneHot & txEmpty) == selOneHot);

    // ==========================================================
    // Write strobes
    // Every strobe already excludes refused accesses, so blocked writes never land
    // no strobe exists for the read-only and reserved registers
    assign wrAbortReq  = wrCommit & hitReg(idx, IDX_ABORT_REQ) & writeOpen;
    assign wrSelect    = wrCommit & hitReg(idx, IDX_TXB_SELECT) & writeOpen;
    // acceptance control opens only in init mode
    assign wrAccept    = wrCommit & hitReg(idx, IDX_ACCEPT_CTL) & initMode;
    assign wrIrqStatus = wrCommit & hitReg(idx, IDX_IRQ_STATUS);
    assign wrIrqMask   = wrCommit & hitReg(idx, IDX_IRQ_MASK);
    // software can only set request bits, never clear them
    assign abortReqSet = wrAbortReq ? wByte[NUM_TXB-1:0] : TXB_RST;

    // ==========================================================
    // Read mux and error decode
    always_comb begin
        readNow = '0;
        errNow  = 1'b0;
        if (apbReq.paddr[1:0] != 2'h0) begin
            errNow = 1'b1;
        end else if (inWindow) begin
            if (winOk) begin
                readNow[7:0] = txBuf_q[selIdx][winOff];
            end else begin
                errNow = 1'b1;
            end
        end else begin
            unique case (idx)
                IDX_ABORT_REQ:  readNow[NUM_TXB-1:0] = abortReq_q;
                IDX_ABORT_ACK:  readNow[NUM_TXB-1:0] = abortAck_q;
                IDX_TXB_SELECT: readNow[NUM_TXB-1:0] = selOneHot;
                IDX_ACCEPT_CTL: begin
                    readNow[MODE_LSB+:2] = mode_q;
                    readNow[HIT_LSB+:3]  = hitIndex_q;
                end
                IDX_RSVD_LO:    readNow = '0;
                IDX_RSVD_HI:    readNow = '0;
                IDX_IRQ_STATUS: readNow[IRQ_W-1:0] = irqStatus_q;
                IDX_IRQ_MASK:   readNow[IRQ_W-1:0] = irqMask_q;
                default:        errNow = 1'b1;
            endcase
        end
    end

    // ==========================================================
    // APB response
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rsp_q <= '0;
        end else begin
            // A write returns zero data so stale read values never leak
            rsp_q.pready <= firstAccess;
            if (firstAccess) begin
                rsp_q.pslverr <= errNow;
                rsp_q.prdata  <= apbReq.pwrite ? '0 : readNow;
            end else begin
                rsp_q.pslverr <= 1'b0;
                rsp_q.prdata  <= '0;
            end
        end
    end

    // ==========================================================
    // Abort request
    always_ff @(posedge clk_sys) begin
        if (!rst_b || initMode) begin
            abortReq_q <= TXB_RST;
        end else begin
            abortReq_q <= (abortReq_q | abortReqSet) & ~txEmpty;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || initMode) begin
            abortGrant <= TXB_RST;
        end else begin
            // Registered for a clean level; costs one cycle of latency
            // grant before start or after failure
            abortGrant <= abortReq_q & ~txEmpty & (~txStarted | txFailed);
        end
    end

    // ==========================================================
    // Abort acknowledge
    assign emptyFall = txEmptyPrev_q & ~txEmpty;
    assign ackSet    = abortDone & abortReq_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            // All empty after reset, so no false clear edge follows it
            txEmptyPrev_q <= TXEMPTY_RST;
        end else begin
            txEmptyPrev_q <= txEmpty;
        end
    end

    always_ff @(posedge clk_sys) begin
        // held in init, no write path
        if (!rst_b || initMode) begin
            abortAck_q <= TXB_RST;
        end else begin
            // clear on empty falling, set wins
            abortAck_q <= (abortAck_q & ~emptyFall) | ackSet;
        end
    end

    // ==========================================================
    // Transmit buffer select
    always_ff @(posedge clk_sys) begin
        if (!rst_b || initMode) begin
            selRaw_q <= TXB_RST;
        end else if (wrSelect) begin
            selRaw_q <= wByte[NUM_TXB-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            txBufSelect <= TXB_RST;
        end else begin
            txBufSelect <= selOneHot;
        end
    end

    // Shared window storage; a refused access never reaches it
    // No reset: contents mean nothing until software loads a buffer
    always_ff @(posedge clk_sys) begin
        if (wrCommit && inWindow) begin
            txBuf_q[selIdx][winOff] <= wByte;
        end
    end

    // ==========================================================
    // Acceptance control
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mode_q <= FILT_TWO32;
        end else if (wrAccept) begin
            mode_q <= cantsa_mode_type'(wByte[MODE_LSB+:2]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            acceptMode   <= FILT_TWO32;
            acceptEnable <= 1'b0;
        end else begin
            acceptMode   <= mode_q;
            acceptEnable <= (mode_q != FILT_CLOSED);
        end
    end

    assign hitUpdate = rxShift && (mode_q != FILT_CLOSED);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hitIndex_q <= HIT_RST;
        // Closed mode keeps the last accepted message's index
        // hit follows foreground
        end else if (hitUpdate) begin
            hitIndex_q <= rxHitIndex;
        end
    end

    // ==========================================================
    // Interrupts
    always_comb begin
        irqEvent              = '0;
        irqEvent[IRQ_ABORT]   = |ackSet;
        irqEvent[IRQ_RXHIT]   = hitUpdate;
        irqEvent[IRQ_BLOCKED] = accessPhase && rsp_q.pready && rsp_q.pslverr && inWindow;
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irqStatus_q <= IRQ_RST;
        end else if (wrIrqStatus) begin
            irqStatus_q <= (irqStatus_q & ~wByte[IRQ_W-1:0]) | irqEvent;
        end else begin
            irqStatus_q <= irqStatus_q | irqEvent;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irqMask_q <= IRQ_RST;
        end else if (wrIrqMask) begin
            irqMask_q <= wByte[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq          <= 1'b0;
            abortRequest <= TXB_RST;
        end else begin
            // One cycle behind status, in exchange for a glitch-free pin
            irq          <= |(irqStatus_q & irqMask_q);
            abortRequest <= abortReq_q;
        end
    end

    assign apbRsp = rsp_q;

endmodule

// ===== sim/cantsa_chk.sv
// Purpose: Concurrent checks on the ports of cantsa_top
// Assumes: One clock domain with a synchronous active-low reset
// Notes:   Bound into every cantsa_top instance
`timescale 1ns/1ps
module cantsa_chk
    import cantsa_pkg::*;
(
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               rst_b,
    // Register bus
    input wire cantsa_apb_req_type apbReq,
    input wire cantsa_apb_rsp_type apbRsp,
    // Controller side
    input wire logic               initRequest,
    input wire logic               initAcknowledge,
    input wire logic [NUM_TXB-1:0] txEmpty,
    input wire logic [NUM_TXB-1:0] txStarted,
    input wire logic [NUM_TXB-1:0] txFailed,
    input wire logic [NUM_TXB-1:0] abortRequest,
    input wire logic [NUM_TXB-1:0] abortGrant,
    input wire logic [NUM_TXB-1:0] txBufSelect,
    input wire cantsa_mode_type    acceptMode,
    input wire logic               acceptEnable
);
    logic initMode;
    logic inWin;

    assign initMode = initRequest && initAcknowledge;
    assign inWin    = apbReq.paddr >= 12'h080 && apbReq.paddr <= 12'h0BC;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // Bus answers
    sequence accTaken;
        apbReq.psel && apbReq.penable && !apbRsp.pready;
    endsequence

    win_nosel_a: assert property (accTaken ##0 (inWin && txBufSelect == 3'h0)
        |=> apbRsp.pslverr) else $error("window access without selection accepted");
    win_busy_a: assert property (accTaken ##0 (inWin && (txBufSelect & ~txEmpty) != 3'h0)
        |=> apbRsp.pslverr && apbRsp.prdata == 32'h0) else $error("busy buffer reached");
    rsvd_zero_a: assert property (accTaken ##0 (apbReq.paddr inside {12'h030, 12'h034})
        |=> apbRsp.prdata == 32'h0 && !apbRsp.pslverr) else $error("reserved pair not zero");
    ack_init_a: assert property (accTaken ##0 (initMode && $past(initMode)
        && apbReq.paddr == 12'h024) |=> apbRsp.prdata == 32'h0) else $error("ack not held");
    sel_read_a: assert property (accTaken ##0 (apbReq.paddr == 12'h028 && !apbReq.pwrite)
        |=> $onehot0(apbRsp.prdata)) else $error("select read not lowest bit");

    // ==========================================================
    // Controller side
    sel_lowest_a: assert property ($onehot0(txBufSelect))
        else $error("more than one buffer mapped");
    sel_held_a: assert property (initMode [*2] |=> txBufSelect == 3'h0)
        else $error("select not held in init mode");
    grant_cond_a: assert property ((abortGrant
        & ~$past(~txEmpty & (~txStarted | txFailed))) == 3'h0) else $error("bad abort grant");
    req_clear_a: assert property ((abortRequest & $past(txEmpty, 2)) == 3'h0)
        else $error("abort request kept on empty buffer");
    closed_mode_a: assert property (acceptMode == FILT_CLOSED |-> !acceptEnable)
        else $error("closed filter still accepts");
endmodule

bind cantsa_top cantsa_chk u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
    .initRequest(initRequest), .initAcknowledge(initAcknowledge), .txEmpty(txEmpty),
    .txStarted(txStarted), .txFailed(txFailed), .abortRequest(abortRequest),
    .abortGrant(abortGrant), .txBufSelect(txBufSelect), .acceptMode(acceptMode),
    .acceptEnable(acceptEnable)
);

// ===== sim/cantsa_ctrl_model.sv
// Purpose: Controller stand-in that schedules, starts and aborts messages
// Assumes: loadBuf is a one-cycle pulse; startBuf and failBuf are levels
// Notes:   slowAbort adds a cycle between grant and abort completion
`timescale 1ns/1ps
module cantsa_ctrl_model
    import cantsa_pkg::*;
(
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    // Bench commands
    input  wire logic [NUM_TXB-1:0] loadBuf,
    input  wire logic [NUM_TXB-1:0] startBuf,
    input  wire logic [NUM_TXB-1:0] failBuf,
    input  wire logic               slowAbort,
    // Design side
    input  wire logic [NUM_TXB-1:0] abortGrant,
    output logic      [NUM_TXB-1:0] txEmpty,
    output logic      [NUM_TXB-1:0] txStarted,
    output logic      [NUM_TXB-1:0] txFailed,
    output logic      [NUM_TXB-1:0] abortDone
);
    logic [NUM_TXB-1:0] pend_q;
    logic [NUM_TXB-1:0] fire;

    // Only full buffers abort, so the lagging grant cannot fire twice
    assign fire = abortGrant & ~txEmpty & (slowAbort ? pend_q : 3'h7);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            txEmpty   <= TXEMPTY_RST;
            pend_q    <= 3'h0;
            abortDone <= 3'h0;
        end else begin
            txEmpty   <= (txEmpty & ~loadBuf) | fire;
            pend_q    <= abortGrant & ~txEmpty;
            abortDone <= fire;
        end
    end

    assign txStarted = startBuf & ~txEmpty;
    assign txFailed  = failBuf & ~txEmpty;
endmodule

// ===== sim/tb.sv
// Purpose: Self-checking bench for cantsa_top
// Assumes: APB master waits for pready; controller side modelled separately
// Notes:   Byte address is four times the register index
`timescale 1ns/1ps
module tb
    import cantsa_pkg::*;
();
    localparam logic [11:0] A_REQ = {IDX_ABORT_REQ, 2'h0};
    localparam logic [11:0] A_ACK = {IDX_ABORT_ACK, 2'h0};
    localparam logic [11:0] A_SEL = {IDX_TXB_SELECT, 2'h0};
    localparam logic [11:0] A_ACC = {IDX_ACCEPT_CTL, 2'h0};
    localparam logic [11:0] A_RSV = {IDX_RSVD_LO, 2'h0};
    localparam logic [11:0] A_STA = {IDX_IRQ_STATUS, 2'h0};
    localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'h0};
    localparam logic [11:0] A_WIN = {IDX_WIN_BASE, 2'h0};

    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    cantsa_apb_req_type apbReq = '0;
    cantsa_apb_rsp_type apbRsp;
    logic initRequest = 1'b0;
    logic initAcknowledge = 1'b0;
    logic [2:0] loadBuf = 3'h0;
    logic [2:0] startBuf = 3'h0;
    logic [2:0] failBuf = 3'h0;
    logic slowAbort = 1'b0;
    logic rxShift = 1'b0;
    logic [2:0] rxHitIndex = 3'h0;
    logic [2:0] txEmpty, txStarted, txFailed, abortDone, abortRequest, abortGrant, txBufSelect;
    cantsa_mode_type acceptMode;
    logic acceptEnable, irq;
    logic [31:0] rdv;
    logic errv;
    int fail_count = 0;
    int n_compared = 0;

    cantsa_top uut (.clk_sys(clk_sys), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp),
        .initRequest(initRequest), .initAcknowledge(initAcknowledge), .txEmpty(txEmpty),
        .txStarted(txStarted), .txFailed(txFailed), .abortDone(abortDone),
        .abortRequest(abortRequest), .abortGrant(abortGrant), .txBufSelect(txBufSelect),
        .rxShift(rxShift), .rxHitIndex(rxHitIndex), .acceptMode(acceptMode),
        .acceptEnable(acceptEnable), .irq(irq));
    cantsa_ctrl_model u_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .loadBuf(loadBuf),
        .startBuf(startBuf), .failBuf(failBuf), .slowAbort(slowAbort),
        .abortGrant(abortGrant), .txEmpty(txEmpty), .txStarted(txStarted),
        .txFailed(txFailed), .abortDone(abortDone));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Helpers
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 20);
        rdv = apbRsp.prdata;
        errv = apbRsp.pslverr;
        apbReq <= '0;
        if (n >= 20) fail_count++;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        apb(1'b0, a, 32'h0);
        chk("prdata", rdv, exp);
        chk("pslverr", {31'h0, errv}, {31'h0, eerr});
    endtask

    task automatic wait_abort(input logic [2:0] b);
        int n;
        n = 0;
        while (abortDone !== b && n < 30) begin
            @(posedge clk_sys);
            n++;
        end
        chk("abortDone", {29'h0, abortDone}, {29'h0, b});
    endtask

    task automatic rx(input logic [2:0] i);
        @(posedge clk_sys);
        rxShift <= 1'b1;
        rxHitIndex <= i;
        @(posedge clk_sys);
        rxShift <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_map();
        rd(A_ACK, 32'h0, 1'b0);
        apb(1'b1, A_RSV, 32'hFF);
        rd(A_RSV, 32'h0, 1'b0);
        rd(A_RSV + 12'h4, 32'h0, 1'b0);
        rd(12'h03C, 32'h0, 1'b1);
    endtask

    task automatic t_select();
        apb(1'b1, A_SEL, 32'h6);
        rd(A_SEL, 32'h2, 1'b0);
        chk("txBufSelect", {29'h0, txBufSelect}, 32'h2);
        apb(1'b1, A_WIN, 32'hA5);
        rd(A_WIN, 32'hA5, 1'b0);
        apb(1'b1, A_SEL, 32'h0);
        rd(A_WIN, 32'h0, 1'b1);
        chk("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, A_MSK, 32'h4);
        @(posedge clk_sys);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, A_STA, 32'h4);
        @(posedge clk_sys);
        chk("irq", {31'h0, irq}, 32'h0);
    endtask

    task automatic t_abort();
        apb(1'b1, A_MSK, 32'h1);
        loadBuf <= 3'h1;
        startBuf <= 3'h1;
        slowAbort <= 1'b1;
        @(posedge clk_sys);
        loadBuf <= 3'h0;
        apb(1'b1, A_SEL, 32'h1);
        rd(A_WIN, 32'h0, 1'b1);
        apb(1'b1, A_REQ, 32'h1);
        repeat (6) @(posedge clk_sys);
        chk("abortGrant", {29'h0, abortGrant}, 32'h0);
        chk("abortRequest", {29'h0, abortRequest}, 32'h1);
        failBuf <= 3'h1;
        wait_abort(3'h1);
        rd(A_REQ, 32'h0, 1'b0);
        rd(A_ACK, 32'h1, 1'b0);
        rd(A_STA, 32'h5, 1'b0);
        chk("irq", {31'h0, irq}, 32'h1);
        loadBuf <= 3'h1;
        @(posedge clk_sys);
        loadBuf <= 3'h2;
        slowAbort <= 1'b0;
        @(posedge clk_sys);
        loadBuf <= 3'h0;
        rd(A_ACK, 32'h0, 1'b0);
        apb(1'b1, A_REQ, 32'h2);
        wait_abort(3'h2);
        rd(A_ACK, 32'h2, 1'b0);
    endtask

    task automatic t_accept();
        apb(1'b1, A_ACC, 32'h30);
        rd(A_ACC, 32'h0, 1'b0);
        initRequest <= 1'b1;
        initAcknowledge <= 1'b1;
        @(posedge clk_sys);
        rd(A_ACK, 32'h0, 1'b0);
        apb(1'b1, A_SEL, 32'h2);
        rd(A_SEL, 32'h0, 1'b0);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, A_ACC, (32'(m) << 4) | 32'h7);
            rd(A_ACC, 32'(m) << 4, 1'b0);
            chk("acceptMode", {30'h0, acceptMode}, 32'(m));
        end
        apb(1'b1, A_ACC, 32'h10);
        rx(3'h5);
        rd(A_ACC, 32'h15, 1'b0);
        apb(1'b1, A_ACC, 32'h30);
        rx(3'h2);
        rd(A_ACC, 32'h35, 1'b0);
        chk("acceptEnable", {31'h0, acceptEnable}, 32'h0);
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_map();
        t_select();
        t_abort();
        t_accept();
        print_verdict();
    end
endmodule
